// ==== tdms_chsel.sv ====
/*
  Multichannel selection for a TDM serial port: partition walk, channel
  enable and mask, current block, block-end interrupt, word hand-over.
  Assumes frame_sync, rx_data_pin and tx_data_pin timed to link_clk rising
  edges, and control inputs synchronous to sys_clk.
*/
`timescale 1ns/1ns
module tdms_chsel
  import tdms_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire tdms_cfg_t            cfg,
  input  wire logic                 tx_data_write,
  input  wire logic [WORD_BITS-1:0] tx_data_in,
  input  wire logic                 rx_data_read,
  output logic      [WORD_BITS-1:0] rx_data_reg,
  output logic                      rx_ready_flag,
  output logic                      rx_dma_event,
  output logic                      tx_ready_flag,
  output logic                      tx_dma_event,
  output logic      [BLK_W-1:0]     rx_current_block,
  output logic      [BLK_W-1:0]     tx_current_block,
  output logic                      rx_block_int,
  output logic                      tx_block_int,
  input  wire logic                 link_clk,
  input  wire logic                 frame_sync,
  input  wire logic                 rx_data_pin,
  output logic                      tx_data_pin,
  output logic                      tx_data_oe
);

  // Enable word of the partition that owns block blk, zero when unassigned
  function automatic logic [CH_W-1:0] part_mask(
    input logic                          eight,
    input logic [SEL_W-1:0]              sel_a,
    input logic [SEL_W-1:0]              sel_b,
    input logic [NUM_PART-1:0][CH_W-1:0] ce,
    input logic [BLK_W-1:0]              blk
  );
    logic [SEL_W-1:0] sel;
    sel = blk[0] ? sel_b : sel_a;
    if (eight)
      part_mask = ce[blk];
    else if (sel == blk[BLK_W-1:1])
      part_mask = ce[{2'h0, blk[0]}];
    else
      part_mask = MASK_NONE;
  endfunction

  // ---------------- System domain ----------------
  logic                 cfg_req_q;
  tdms_cfg_t            cfg_snap_q;
  logic                 txd_req_q;
  logic [WORD_BITS-1:0] txd_snap_q;
  logic [1:0]           ack_s1_q;
  logic [1:0]           ack_s2_q;
  logic [3:0]           l2s_s1_q;
  logic [3:0]           l2s_s2_q;
  logic [3:0]           l2s_s3_q;
  logic [3:0]           l2s_edge;
  logic [INT_LEN-1:0]   rx_int_q;
  logic [INT_LEN-1:0]   tx_int_q;
  logic                 rx_ready_q;
  logic                 tx_ready_q;
  logic                 rx_dma_q;
  logic                 tx_dma_q;
  logic [WORD_BITS-1:0] rx_data_q;
  logic [BLK_W-1:0]     rx_blk_q;
  logic [BLK_W-1:0]     tx_blk_q;

  // ---------------- Link domain ----------------
  logic                 cfg_ack_q;
  logic                 txd_ack_q;
  logic [1:0]           req_s1_q;
  logic [1:0]           req_s2_q;
  tdms_cfg_t            shadow_q;
  logic [WORD_BITS-1:0] tx_hold_q;
  logic                 active_q;
  logic [BIT_W-1:0]     bit_q;
  logic [SLOT_W-1:0]    slot_q;
  logic [CH_W-1:0]      rx_mask_q;
  logic [CH_W-1:0]      tx_mask_q;
  logic                 rx_en_q;
  logic [WORD_BITS-1:0] rx_buf_q;
  logic [WORD_BITS-1:0] rx_hold_q;
  logic [WORD_BITS-1:0] tx_shift_q;
  logic                 tx_oe_q;
  logic [BLK_W-1:0]     cur_blk_q;
  logic                 rx_word_tgl_q;
  logic                 tx_copy_tgl_q;
  logic                 blk_start_tgl_q;
  logic                 blk_end_tgl_q;

  logic                 n_active;
  logic [BIT_W-1:0]     n_bit;
  logic [SLOT_W-1:0]    n_slot;
  logic                 slot_entry;
  logic                 blk_entry;
  logic                 blk_end;
  logic                 word_done;
  logic [CH_W-1:0]      rx_mask_n;
  logic [CH_W-1:0]      tx_mask_n;
  logic                 rx_sel_n;
  logic                 tx_sel_n;
  logic                 tx_en_n;
  logic                 tx_unmask_n;

  // Control snapshot crosses as a toggle handshake; snapshot holds while in flight
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_req_q  <= 1'b0;
      cfg_snap_q <= '0;
    end
    else if (ack_s2_q[0] == cfg_req_q)
    begin
      cfg_snap_q <= cfg;
      cfg_req_q  <= ~cfg_req_q;
    end
  end

  // Transmit word crosses the same way; a write while busy is dropped
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txd_req_q  <= 1'b0;
      txd_snap_q <= WORD_ZERO;
    end
    else if (tx_data_write && (ack_s2_q[1] == txd_req_q))
    begin
      txd_snap_q <= tx_data_in;
      txd_req_q  <= ~txd_req_q;
    end
  end

  // Synchronisers for acknowledges and link event toggles
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_s1_q <= 2'h0;
      ack_s2_q <= 2'h0;
      l2s_s1_q <= 4'h0;
      l2s_s2_q <= 4'h0;
      l2s_s3_q <= 4'h0;
    end
    else
    begin
      ack_s1_q <= {txd_ack_q, cfg_ack_q};
      ack_s2_q <= ack_s1_q;
      l2s_s1_q <= {blk_end_tgl_q, blk_start_tgl_q, tx_copy_tgl_q, rx_word_tgl_q};
      l2s_s2_q <= l2s_s1_q;
      l2s_s3_q <= l2s_s2_q;
    end
  end

  assign l2s_edge = l2s_s2_q ^ l2s_s3_q;

  // Current block captured when a block starts; stable for the whole block
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_blk_q <= BLK_ZERO;
      tx_blk_q <= BLK_ZERO;
    end
    else if (l2s_edge[2])
    begin
      rx_blk_q <= cur_blk_q;
      tx_blk_q <= cur_blk_q;
    end
  end

  // Block-end interrupt pulses, two cycles long
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_int_q <= '0;
      tx_int_q <= '0;
    end
    else
    begin
      rx_int_q <= {rx_int_q[0],
                   l2s_edge[3] && cfg.rx_int_mode && cfg.rx_multichan_mode};
      tx_int_q <= {tx_int_q[0],
                   l2s_edge[3] && cfg.tx_int_mode
                   && (cfg.tx_multichan_mode != TX_ALL)};
    end
  end

  // Receive word hand-over and ready flag; a new word wins over a read
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_data_q  <= WORD_ZERO;
      rx_ready_q <= 1'b0;
      rx_dma_q   <= 1'b0;
    end
    else
    begin
      rx_dma_q <= l2s_edge[0];
      if (l2s_edge[0])
      begin
        rx_data_q  <= rx_hold_q;
        rx_ready_q <= 1'b1;
      end
      else if (rx_data_read)
        rx_ready_q <= 1'b0;
    end
  end

  // Transmit ready rises only when a word reached the shifter
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_ready_q <= 1'b1;
      tx_dma_q   <= 1'b0;
    end
    else
    begin
      tx_dma_q <= l2s_edge[1];
      if (l2s_edge[1])
        tx_ready_q <= 1'b1;
      else if (tx_data_write)
        tx_ready_q <= 1'b0;
    end
  end

  assign rx_data_reg      = rx_data_q;
  assign rx_ready_flag    = rx_ready_q;
  assign rx_dma_event     = rx_dma_q;
  assign tx_ready_flag    = tx_ready_q;
  assign tx_dma_event     = tx_dma_q;
  assign rx_current_block = rx_blk_q;
  assign tx_current_block = tx_blk_q;
  assign rx_block_int     = |rx_int_q;
  assign tx_block_int     = |tx_int_q;

  // Link side of both handshakes
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_s1_q  <= 2'h0;
      req_s2_q  <= 2'h0;
      cfg_ack_q <= 1'b0;
      txd_ack_q <= 1'b0;
      shadow_q  <= '0;
      tx_hold_q <= WORD_ZERO;
    end
    else
    begin
      req_s1_q <= {txd_req_q, cfg_req_q};
      req_s2_q <= req_s1_q;
      if (req_s2_q[0] != cfg_ack_q)
      begin
        shadow_q  <= cfg_snap_q;
        cfg_ack_q <= req_s2_q[0];
      end
      if (req_s2_q[1] != txd_ack_q)
      begin
        tx_hold_q <= txd_snap_q;
        txd_ack_q <= req_s2_q[1];
      end
    end
  end

  // Frame walk: word counter whose block bits name the partition in turn
  always_comb
  begin
    n_active  = active_q;
    n_bit     = bit_q + 3'h1;
    n_slot    = slot_q;
    word_done = active_q && (bit_q == BIT_LAST);
    blk_end   = word_done && ((slot_q[CH_IDX_W-1:0] == CH_LAST)
                              || (slot_q == shadow_q.frame_last_word));
    if (frame_sync)
    begin
      n_active = 1'b1;
      n_bit    = BIT_FIRST;
      n_slot   = SLOT_ZERO;
    end
    else if (word_done)
    begin
      if (slot_q == shadow_q.frame_last_word)
        n_active = 1'b0;
      else
        n_slot = slot_q + 7'h01;
    end
    slot_entry = n_active && (n_bit == BIT_FIRST);
    blk_entry  = slot_entry && (n_slot[CH_IDX_W-1:0] == CH_FIRST);
  end

  // Partition setup is taken fresh only as its block begins
  always_comb
  begin
    rx_mask_n = rx_mask_q;
    tx_mask_n = tx_mask_q;
    if (blk_entry)
    begin
      rx_mask_n = part_mask(shadow_q.rx_eight_part_enable, shadow_q.rx_part_a_block_sel,
                            shadow_q.rx_part_b_block_sel, shadow_q.rx_chan_enable_reg,
                            n_slot[SLOT_W-1:CH_IDX_W]);
      tx_mask_n = part_mask(shadow_q.tx_eight_part_enable, shadow_q.tx_part_a_block_sel,
                            shadow_q.tx_part_b_block_sel, shadow_q.tx_chan_enable_reg,
                            n_slot[SLOT_W-1:CH_IDX_W]);
    end
    rx_sel_n = rx_mask_n[n_slot[CH_IDX_W-1:0]];
    tx_sel_n = tx_mask_n[n_slot[CH_IDX_W-1:0]];
  end

  // Transmit enable and mask per mode
  always_comb
  begin
    unique case (shadow_q.tx_multichan_mode)
      TX_ALL:
      begin
        tx_en_n     = 1'b1;
        tx_unmask_n = 1'b1;
      end
      TX_SELECT:
      begin
        tx_en_n     = tx_sel_n;
        tx_unmask_n = tx_sel_n;
      end
      TX_MASK:
      begin
        tx_en_n     = 1'b1;
        tx_unmask_n = tx_sel_n;
      end
      TX_SYMMETRIC:
      begin
        tx_en_n     = rx_sel_n;
        tx_unmask_n = rx_sel_n && tx_sel_n;
      end
    endcase
  end

  // Counters, latched partition setup, current block and block events
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      active_q        <= 1'b0;
      bit_q           <= BIT_FIRST;
      slot_q          <= SLOT_ZERO;
      rx_mask_q       <= MASK_NONE;
      tx_mask_q       <= MASK_NONE;
      cur_blk_q       <= BLK_ZERO;
      blk_start_tgl_q <= 1'b0;
      blk_end_tgl_q   <= 1'b0;
    end
    else
    begin
      active_q  <= n_active;
      bit_q     <= n_bit;
      slot_q    <= n_slot;
      rx_mask_q <= rx_mask_n;
      tx_mask_q <= tx_mask_n;
      if (blk_entry)
      begin
        cur_blk_q       <= n_slot[SLOT_W-1:CH_IDX_W];
        blk_start_tgl_q <= ~blk_start_tgl_q;
      end
      if (blk_end)
        blk_end_tgl_q <= ~blk_end_tgl_q;
    end
  end

  // Receive shifting; only enabled words go past the buffer
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_en_q       <= 1'b0;
      rx_buf_q      <= WORD_ZERO;
      rx_hold_q     <= WORD_ZERO;
      rx_word_tgl_q <= 1'b0;
    end
    else
    begin
      if (slot_entry)
        rx_en_q <= !shadow_q.rx_multichan_mode || rx_sel_n;
      if (active_q)
        rx_buf_q <= {rx_buf_q[WORD_BITS-2:0], rx_data_pin};
      if (word_done && rx_en_q)
      begin
        rx_hold_q     <= {rx_buf_q[WORD_BITS-2:0], rx_data_pin};
        rx_word_tgl_q <= ~rx_word_tgl_q;
      end
    end
  end

  // Transmit shifter and pin drive
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_shift_q    <= WORD_ZERO;
      tx_oe_q       <= 1'b0;
      tx_copy_tgl_q <= 1'b0;
    end
    else if (slot_entry)
    begin
      tx_oe_q <= tx_en_n && tx_unmask_n;
      if (tx_en_n)
      begin
        tx_shift_q    <= tx_hold_q;
        tx_copy_tgl_q <= ~tx_copy_tgl_q;
      end
    end
    else
    begin
      tx_shift_q <= {tx_shift_q[WORD_BITS-2:0], 1'b0};
      if (!n_active)
        tx_oe_q <= 1'b0;
    end
  end

  assign tx_data_pin = tx_shift_q[WORD_BITS-1];
  assign tx_data_oe  = tx_oe_q;

endmodule

// ==== tdms_pkg.sv ====
/*
  Shared constants and types for the TDM multichannel selection block.
  Assumes a single-phase frame of fixed-length words on one link clock
  and frame sync, and control bits driven from the system clock domain.
*/
// Behaviour
// - Two partitions: A select 0..3 picks blocks 0,2,4,6; B select picks 1,3,5,7.
// - Two partitions: frame starts in A, then alternates B and A to frame end.
// - Current block being received and transmitted is readable separately.
// - An interrupt can be raised at every block end and at frame end.
// - Eight partitions: frame starts at A, runs A through H, 128 words.
// - Eight partitions: block selects ignored, block n fixed to partition n.
// - Each partition has a 16-bit enable word per direction, bit n is channel n.
// - Receive mode bit 0: all 128 receive channels enabled.
// - Receive mode bit 1: only channels set in the partition enable word.
// - Disabled receive word stops in buffer: no copy, no ready, no DMA event.
// - Transmit mode 0: every channel enabled and unmasked.
// - Transmit mode 1: enabled only when selected, enabled means unmasked.
// - Transmit mode 2: all enabled, masked unless selected.
// - Transmit mode 3: enabled by receive selection, unmasked by transmit selection.
// - Partition count sets whether 32 or 128 channels are selectable.
// - Data pin released in disabled or masked slots, driven only otherwise.
// - Disabled transmit slot: no copy to shifter, no ready, no DMA event.
// - Block-end interrupt only with its int mode bit and a selection mode on.
// - Block-end interrupt is a high pulse of two system clock cycles.
package tdms_pkg;

  localparam int unsigned WORD_BITS = 8;
  localparam int unsigned BIT_W     = 3;
  localparam int unsigned SLOT_W    = 7;
  localparam int unsigned BLK_W     = 3;
  localparam int unsigned SEL_W     = 2;
  localparam int unsigned CH_W      = 16;
  localparam int unsigned NUM_PART  = 8;
  localparam int unsigned CH_IDX_W  = 4;
  localparam int unsigned INT_LEN   = 2;

  localparam logic [BIT_W-1:0]    BIT_LAST  = 3'h7;
  localparam logic [BIT_W-1:0]    BIT_FIRST = 3'h0;
  localparam logic [CH_IDX_W-1:0] CH_LAST   = 4'hF;
  localparam logic [CH_IDX_W-1:0] CH_FIRST  = 4'h0;
  localparam logic [SLOT_W-1:0]   SLOT_ZERO = 7'h00;
  localparam logic [BLK_W-1:0]    BLK_ZERO  = 3'h0;
  localparam logic [WORD_BITS-1:0] WORD_ZERO = 8'h00;
  localparam logic [CH_W-1:0]     MASK_ALL  = 16'hFFFF;
  localparam logic [CH_W-1:0]     MASK_NONE = 16'h0000;

  typedef enum logic [1:0]
  {
    TX_ALL       = 2'h0,
    TX_SELECT    = 2'h1,
    TX_MASK      = 2'h2,
    TX_SYMMETRIC = 2'h3
  } tdms_tx_mode_t;

  typedef struct packed
  {
    logic [SEL_W-1:0]              rx_part_a_block_sel;
    logic [SEL_W-1:0]              rx_part_b_block_sel;
    logic [SEL_W-1:0]              tx_part_a_block_sel;
    logic [SEL_W-1:0]              tx_part_b_block_sel;
    logic                          rx_multichan_mode;
    logic                          rx_eight_part_enable;
    tdms_tx_mode_t                 tx_multichan_mode;
    logic                          tx_eight_part_enable;
    logic                          rx_int_mode;
    logic                          tx_int_mode;
    logic [SLOT_W-1:0]             frame_last_word;
    logic [NUM_PART-1:0][CH_W-1:0] rx_chan_enable_reg;
    logic [NUM_PART-1:0][CH_W-1:0] tx_chan_enable_reg;
  } tdms_cfg_t;

endpackage

// ==== tdms_chsel_asserts.sv ====
/*
  Checker for the TDM multichannel selection block.
  Sees only top-level ports; bound from the testbench top file.
*/
`timescale 1ns/1ns
module tdms_chsel_asserts
  import tdms_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             reset_n,
  input wire logic             link_clk,
  input wire tdms_cfg_t        cfg,
  input wire logic [7:0]       rx_data_reg,
  input wire logic             rx_dma_event,
  input wire logic             tx_ready_flag,
  input wire logic             tx_dma_event,
  input wire logic [BLK_W-1:0] rx_current_block,
  input wire logic [BLK_W-1:0] tx_current_block,
  input wire logic             rx_block_int,
  input wire logic             tx_block_int,
  input wire logic             tx_data_oe
);
  chk_rx_int_len: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(rx_block_int) |=> rx_block_int ##1 !rx_block_int)
    else $error("rx block int length wrong");
  chk_tx_int_len: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(tx_block_int) |=> tx_block_int ##1 !tx_block_int)
    else $error("tx block int length wrong");
  chk_rx_int_gate: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    rx_block_int |-> cfg.rx_int_mode && cfg.rx_multichan_mode)
    else $error("rx block int while not allowed");
  chk_tx_int_gate: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    tx_block_int |-> cfg.tx_int_mode && (cfg.tx_multichan_mode != TX_ALL))
    else $error("tx block int while not allowed");
  chk_rx_data_dma: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $changed(rx_data_reg) |-> rx_dma_event)
    else $error("rx data changed without dma event");
  chk_tx_ready_dma: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(tx_ready_flag) |-> tx_dma_event)
    else $error("tx ready set without dma event");
  chk_oe_word: assert property (
    @(posedge link_clk) disable iff (!reset_n)
    $rose(tx_data_oe) |-> tx_data_oe [*8])
    else $error("tx drive enable shorter than a word");
  chk_block_step: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $changed(rx_current_block) |-> (rx_current_block == BLK_ZERO) ||
      (rx_current_block == 3'($past(rx_current_block) + 3'h1)))
    else $error("current block skipped");
  chk_block_same: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    rx_current_block == tx_current_block)
    else $error("rx and tx current block differ");
endmodule

// ==== tdms_line_model.sv ====
/*
  Far side of the TDM line: link clock, frame sync and receive words.
  Records transmit words and drive enable per slot; assumes the block
  samples and launches on link_clk rising edges.
*/
`timescale 1ns/1ns
module tdms_line_model
(
  output logic      link_clk,
  output logic      frame_sync,
  output logic      rx_data_pin,
  input  wire logic tx_data_pin,
  input  wire logic tx_data_oe
);
  logic [7:0] tx_cap [129];
  logic       oe_any [129];

  initial
  begin
    link_clk = 1'b0;
    frame_sync = 1'b0;
    rx_data_pin = 1'b0;
  end

  task automatic tick();
    #15 link_clk = 1'b0;
    #16 link_clk = 1'b1;
    #1;
  endtask

  // Released line keeps toggling
  task automatic idle(input int n);
    repeat (n)
    begin
      rx_data_pin = ~rx_data_pin;
      tick();
    end
  endtask

  // Clock runs only around a frame
  task automatic run_frame(input int n);
    logic [7:0] d;
    idle(20);
    frame_sync = 1'b1;
    tick();
    frame_sync = 1'b0;
    for (int w = 0; w < n; w++)
    begin
      d = 8'(w * 7) ^ 8'h3C;
      oe_any[w] = 1'b0;
      for (int k = 7; k >= 0; k--)
      begin
        oe_any[w] = oe_any[w] | tx_data_oe;
        tx_cap[w] = {tx_cap[w][6:0], tx_data_pin};
        rx_data_pin = d[k];
        tick();
      end
    end
    oe_any[n] = tx_data_oe;
    idle(40);
  endtask
endmodule

// ==== tb_top.sv ====
/*
  Testbench for the TDM multichannel selection block.
  Drives control ports on sys_clk; the line model runs the link side.
*/
`timescale 1ns/1ns
module tb_top
  import tdms_pkg::*;
;
  logic sys_clk, reset_n, tx_data_write, rx_data_read, link_clk, frame_sync;
  logic rx_data_pin, tx_data_pin, tx_data_oe, rx_ready_flag, rx_dma_event;
  logic tx_ready_flag, tx_dma_event, rx_block_int, tx_block_int, rx_ip, tx_ip;
  logic [7:0]       tx_data_in, rx_data_reg, rx_last;
  logic [BLK_W-1:0] rx_current_block, tx_current_block, blk_prev;
  logic [BLK_W-1:0] blk_log [$];
  tdms_cfg_t        cfg;
  int n_mismatch = 0, checks_done = 0, rx_dc, tx_dc, rx_ic, tx_ic;

  tdms_chsel tdms_chsel_inst (.sys_clk, .reset_n, .cfg, .tx_data_write, .tx_data_in,
    .rx_data_read, .rx_data_reg, .rx_ready_flag, .rx_dma_event, .tx_ready_flag,
    .tx_dma_event, .rx_current_block, .tx_current_block, .rx_block_int, .tx_block_int,
    .link_clk, .frame_sync, .rx_data_pin, .tx_data_pin, .tx_data_oe);
  tdms_line_model tdms_line_model_inst (.link_clk, .frame_sync, .rx_data_pin,
    .tx_data_pin, .tx_data_oe);

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    rx_dc += int'(rx_dma_event === 1'b1);
    tx_dc += int'(tx_dma_event === 1'b1);
    rx_ic += int'(rx_block_int === 1'b1 && rx_ip !== 1'b1);
    tx_ic += int'(tx_block_int === 1'b1 && tx_ip !== 1'b1);
    if (rx_current_block !== blk_prev && rx_current_block !== 3'h0)
      blk_log.push_back(rx_current_block);
    rx_ip = rx_block_int;
    tx_ip = tx_block_int;
    blk_prev = rx_current_block;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Channel w selected by its partition enable word
  function automatic logic sel(input logic [NUM_PART-1:0][CH_W-1:0] ce,
    input logic [1:0] a, input logic [1:0] b, input logic e8, input int w);
    int b_n;
    b_n = w / 16;
    if (e8)
      return ce[b_n][w % 16];
    if (b_n == 2 * a)
      return ce[0][w % 16];
    if (b_n == 2 * b + 1)
      return ce[1][w % 16];
    return 1'b0;
  endfunction

  task automatic mode(input logic rxm, input logic e8, input tdms_tx_mode_t txm,
    input logic [1:0] sa, input logic [1:0] sb);
    @(posedge sys_clk);
    cfg.rx_multichan_mode <= rxm;
    cfg.tx_multichan_mode <= txm;
    cfg.rx_eight_part_enable <= e8;
    cfg.tx_eight_part_enable <= e8;
    cfg.rx_part_a_block_sel <= sa;
    cfg.tx_part_a_block_sel <= sa;
    cfg.rx_part_b_block_sel <= sb;
    cfg.tx_part_b_block_sel <= sb;
  endtask

  // One frame of n words, then every slot compared
  task automatic run(input int n, input logic [7:0] txw);
    logic r, t, en, um, any_en;
    int nr, nb;
    #1;
    nr = 0;
    any_en = 1'b0;
    nb = (n + 15) / 16;
    rx_dc = 0;
    tx_dc = 0;
    rx_ic = 0;
    tx_ic = 0;
    blk_log.delete();
    @(posedge sys_clk);
    cfg.frame_last_word <= 7'(n - 1);
    tx_data_write <= 1'b1;
    tx_data_in <= txw;
    @(posedge sys_clk);
    tx_data_write <= 1'b0;
    tdms_line_model_inst.run_frame(n);
    for (int w = 0; w < n; w++)
    begin
      r = sel(cfg.rx_chan_enable_reg, cfg.rx_part_a_block_sel, cfg.rx_part_b_block_sel,
        cfg.rx_eight_part_enable, w);
      t = sel(cfg.tx_chan_enable_reg, cfg.tx_part_a_block_sel, cfg.tx_part_b_block_sel,
        cfg.tx_eight_part_enable, w);
      en = (cfg.tx_multichan_mode inside {TX_ALL, TX_MASK}) ? 1'b1 :
        (cfg.tx_multichan_mode == TX_SELECT) ? t : r;
      um = (cfg.tx_multichan_mode == TX_ALL) ? 1'b1 : (en & t);
      check(16'(tdms_line_model_inst.oe_any[w]), 16'(um));
      if (um)
        check(16'(tdms_line_model_inst.tx_cap[w]), 16'(txw));
      if (!cfg.rx_multichan_mode || r)
      begin
        nr++;
        rx_last = 8'(w * 7) ^ 8'h3C;
      end
      any_en = any_en | en;
    end
    check(16'(tdms_line_model_inst.oe_any[n]), 16'h0000);
    check(16'(rx_dc), 16'(nr));
    check(16'(rx_data_reg), 16'(rx_last));
    check(16'(rx_ready_flag), 16'(nr != 0));
    check(16'(tx_ready_flag), 16'(any_en));
    check(16'(tx_dc != 0), 16'(any_en));
    check(16'(rx_ic), (cfg.rx_int_mode && cfg.rx_multichan_mode) ? 16'(nb) : 16'h0);
    check(16'(tx_ic), (cfg.tx_int_mode && cfg.tx_multichan_mode != TX_ALL) ?
      16'(nb) : 16'h0);
    check(16'(blk_log.size()), 16'(nb - 1));
    check(16'(rx_current_block), 16'(nb - 1));
    check(16'(tx_current_block), 16'(nb - 1));
    foreach (blk_log[i])
      check(16'(blk_log[i]), 16'(i + 1));
    @(posedge sys_clk);
    rx_data_read <= 1'b1;
    @(posedge sys_clk);
    rx_data_read <= 1'b0;
    $display("frame of %0d words done", n);
  endtask

  initial
  begin
    #1000000;
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    cfg = '0;
    tx_data_write = 1'b0;
    tx_data_in = 8'h00;
    rx_data_read = 1'b0;
    reset_n = 1'b0;
    rx_last = 8'h00;
    blk_prev = 3'h0;
    fork
      repeat (2) @(posedge sys_clk);
      repeat (3) tdms_line_model_inst.tick();
    join
    @(posedge sys_clk);
    reset_n <= 1'b1;
    cfg.rx_int_mode <= 1'b1;
    cfg.tx_int_mode <= 1'b1;
    run(4, 8'hA5);
    mode(1'b1, 1'b0, TX_SELECT, 2'h3, 2'h1);
    cfg.rx_chan_enable_reg <= {8{16'h0822}};
    cfg.tx_chan_enable_reg <= {8{16'h0300}};
    fork
      run(64, 8'h5C);
      begin
        wait (rx_current_block === 3'h1);
        @(posedge sys_clk);
        cfg.rx_part_a_block_sel <= 2'h1;
        cfg.tx_part_a_block_sel <= 2'h1;
      end
    join
    for (int s = 0; s < 4; s++)
    begin
      mode(1'b1, 1'b0, TX_SELECT, 2'(s), 2'(3 - s));
      run(128, 8'(8'h11 * s));
    end
    mode(1'b1, 1'b1, TX_MASK, 2'h2, 2'h2);
    cfg.rx_chan_enable_reg <= {16'h0100, 16'h0010, 16'h2000, 16'h0004,
      16'h0000, 16'h4000, 16'h0020, 16'h0002};
    cfg.tx_chan_enable_reg <= {16'h0002, 16'h0000, 16'h0400, 16'h0001,
      16'h1000, 16'h0080, 16'h0008, 16'h0200};
    cfg.tx_int_mode <= 1'b0;
    run(128, 8'hC3);
    mode(1'b1, 1'b0, TX_SYMMETRIC, 2'h2, 2'h2);
    cfg.rx_chan_enable_reg <= {8{16'h0A0A}};
    cfg.tx_chan_enable_reg <= {8{16'h0808}};
    cfg.tx_int_mode <= 1'b1;
    run(96, 8'h3E);
    mode(1'b1, 1'b0, TX_SELECT, 2'h0, 2'h0);
    cfg.rx_chan_enable_reg <= '0;
    cfg.tx_chan_enable_reg <= '0;
    run(20, 8'h77);
    end_of_test();
  end
endmodule

bind tdms_chsel tdms_chsel_asserts tdms_chsel_asserts_inst (.sys_clk, .reset_n, .link_clk,
  .cfg, .rx_data_reg, .rx_dma_event, .tx_ready_flag, .tx_dma_event, .rx_current_block,
  .tx_current_block, .rx_block_int, .tx_block_int, .tx_data_oe);
